// [core/pwm_output_level_select.sv]
// Summary of operation
// - Second output control register is 8-bit read/write, zero after reset.
// - Level settings apply only in complementary and reset-synchronized PWM modes.
// - Bits 7:6 choose the buffer copy point; 00 never copies.
// - Complementary mode, code 01: copy buffer at channel-four counter crest.
// - Complementary mode, code 10: copy buffer at channel-four counter trough.
// - Complementary mode, code 11: copy buffer at crest and trough.
// - Reset-synchronized mode, code 01: copy on counter clear; 10 and 11 forbidden.
// - Six level bits take effect only while table select is one.
// - Bits 5, 3, 1 drive ch4_out_d, ch4_out_c, ch3_out_d.
// - Bits 4, 2, 0 drive ch4_out_b, ch4_out_a, ch3_out_b.
// - Reverse bit zero: idle high, active low; one inverts.
// - Positive bit zero: idle high, active low; one inverts.
// - Reverse outputs hold initial level until dead time passes after start.
// - Separate buffer register bits 5:0 feed the copied level bits.
// - Table select zero: first register's single level bits set polarity.
`default_nettype none
module pwm_output_level_select
	import pwm_level_pkg::*;
#(
	parameter int DEAD_CNT = DEAD_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        crest_i,
	input  wire logic        trough_i,
	input  wire logic        clear_i,
	input  wire logic        counting_i,
	input  wire logic [5:0]  phase_on_i,
	output logic             ch4_out_d_o,
	output logic             ch4_out_b_o,
	output logic             ch4_out_c_o,
	output logic             ch4_out_a_o,
	output logic             ch3_out_d_o,
	output logic             ch3_out_b_o
);

	localparam int DW = $clog2(DEAD_CNT + 1);
	localparam logic [DW-1:0] DEAD_LAST = DW'(DEAD_CNT);
	localparam logic [DW-1:0] DEAD_ONE  = DW'(1);

	logic [2:0]  one_r;
	level_two_t  two_r;
	level_two_t  two_nxt;
	logic [5:0]  buf_r;
	logic [1:0]  mode_r;
	logic        ack_r;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	logic [DW-1:0] dt_r;
	logic [DW-1:0] dt_nxt;
	logic [5:0]  out_r;
	logic [5:0]  out_nxt;

	// Decides whether the current counter event triggers a buffer copy.
	function automatic logic copy_due(input logic [1:0] mode, input logic [1:0] tim,
			input logic crest, input logic trough, input logic clr);
		logic due;
		due = 1'b0;
		unique case (pwm_mode_t'(mode))
			MODE_COMPL: due = (tim[0] & crest) | (tim[1] & trough);
			MODE_RSYNC: due = (tim == COPY_CREST) & clr;
			MODE_NORMAL: due = 1'b0;
			default: due = 1'b0;
		endcase
		return due;
	endfunction

	// Bus decode; a request is taken once, in the cycle before ack.
	wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
	wire wr_one   = wr_lane0 & (wb_adr_i == ADDR_ONE);
	wire wr_two   = wr_lane0 & (wb_adr_i == ADDR_TWO);
	wire wr_buf   = wr_lane0 & (wb_adr_i == ADDR_BUF);
	wire wr_mode  = wr_lane0 & (wb_adr_i == ADDR_MODE);

	// Mode, copy event and level table selection.
	wire pwm_mode = (mode_r == MODE_COMPL) | (mode_r == MODE_RSYNC);
	wire do_copy  = copy_due(mode_r, two_r.copy_timing, crest_i, trough_i, clear_i);
	wire [5:0] one_levels = {3{one_r[ONE_REV_BIT], one_r[ONE_POS_BIT]}};
	wire [5:0] eff_levels = one_r[ONE_TSEL_BIT] ? two_r.levels : one_levels;
	wire dead_done = (dt_r == DEAD_LAST);

	// Next value of the second register; a copy overrides a write of the level bits.
	always_comb begin
		two_nxt = two_r;
		if (wr_two) begin
			two_nxt = level_two_t'(wb_dat_i[7:0]);
		end
		if (do_copy) begin
			two_nxt.levels = buf_r;
		end
	end

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		rdat_nxt = 32'h0000_0000;
		unique case (wb_adr_i)
			ADDR_ONE:  rdat_nxt[2:0] = one_r;
			ADDR_TWO:  rdat_nxt[7:0] = two_r;
			ADDR_BUF:  rdat_nxt[5:0] = buf_r;
			ADDR_MODE: rdat_nxt[1:0] = mode_r;
			default:   rdat_nxt = 32'h0000_0000;
		endcase
	end

	// Dead-time counter restarts whenever counting stops.
	always_comb begin
		dt_nxt = dt_r;
		if (!counting_i) begin
			dt_nxt = '0;
		end else if (!dead_done) begin
			dt_nxt = dt_r + DEAD_ONE;
		end
	end

	// Pin levels: active level is the bit, initial level its inverse.
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin
			localparam bit IS_REV = REV_MASK[gi];
			wire on_w = counting_i & phase_on_i[gi] & (~IS_REV | dead_done);
			assign out_nxt[gi] = pwm_mode ? (on_w ? eff_levels[gi] : ~eff_levels[gi])
				: phase_on_i[gi];
		end
	endgenerate

	// Registers and bus answer.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			one_r  <= ONE_RESET;
			two_r  <= TWO_RESET;
			buf_r  <= LEVEL_RESET;
			mode_r <= MODE_RESET;
			ack_r  <= 1'b0;
			rdat_r <= 32'h0000_0000;
			dt_r   <= '0;
			out_r  <= LEVEL_RESET;
		end else begin
			if (wr_one) one_r <= wb_dat_i[2:0];
			if (wr_buf) buf_r <= wb_dat_i[5:0];
			if (wr_mode) mode_r <= wb_dat_i[1:0];
			two_r  <= two_nxt;
			ack_r  <= wb_cyc_i & wb_stb_i & ~ack_r;
			rdat_r <= rdat_nxt;
			dt_r   <= dt_nxt;
			out_r  <= out_nxt;
		end
	end

	assign wb_ack_o    = ack_r;
	assign wb_dat_o    = rdat_r;
	assign ch4_out_d_o = out_r[5];
	assign ch4_out_c_o = out_r[3];
	assign ch3_out_d_o = out_r[1];
	assign ch4_out_b_o = out_r[4];
	assign ch4_out_a_o = out_r[2];
	assign ch3_out_b_o = out_r[0];

	// Checks on the copy points, polarity and the register.
	sequence crest_only_s;
		(mode_r == MODE_COMPL) && (two_r.copy_timing == COPY_CREST) && crest_i;
	endsequence
	sequence trough_only_s;
		(mode_r == MODE_COMPL) && (two_r.copy_timing == COPY_TROUGH) && trough_i;
	endsequence
	sequence both_trough_s;
		(mode_r == MODE_COMPL) && (two_r.copy_timing == COPY_BOTH) && trough_i;
	endsequence
	sequence clear_copy_s;
		(mode_r == MODE_RSYNC) && (two_r.copy_timing == COPY_CREST) && clear_i;
	endsequence
	sequence both_crest_s;
		(mode_r == MODE_COMPL) && (two_r.copy_timing == COPY_BOTH) && crest_i;
	endsequence
	sequence rev_on_s;
		pwm_mode && counting_i && dead_done && one_r[ONE_TSEL_BIT];
	endsequence
	sequence pos_on_s;
		pwm_mode && counting_i && one_r[ONE_TSEL_BIT];
	endsequence

	crest_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		crest_only_s |=> two_r.levels == $past(buf_r))
		else $error("crest copy missed");
	trough_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		trough_only_s |=> two_r.levels == $past(buf_r))
		else $error("trough copy missed");
	both_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		both_trough_s |=> two_r.levels == $past(buf_r))
		else $error("both-point copy missed");
	clear_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_copy_s |=> two_r.levels == $past(buf_r))
		else $error("clear copy missed");
	no_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(two_r.copy_timing == COPY_NONE) && !wr_two |=> $stable(two_r.levels))
		else $error("copy with timing none");
	table_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_mode && !one_r[ONE_TSEL_BIT] && !counting_i
		|=> out_r == ~{3{$past(one_r[ONE_REV_BIT]), $past(one_r[ONE_POS_BIT])}})
		else $error("wrong level table");
	dead_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_mode && !dead_done |=> (out_r & REV_MASK) == (~$past(eff_levels) & REV_MASK))
		else $error("reverse left initial level early");
	idle_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_mode && !counting_i |=> out_r == ~$past(eff_levels))
		else $error("idle level wrong");
	reset_zero_a: assert property (@(posedge clk_i)
		rst_i |=> (two_r == TWO_RESET) && (out_r == LEVEL_RESET))
		else $error("reset value wrong");
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// A crest also copies when both copy points are selected.
	crest_both_a: assert property (@(posedge clk_i) disable iff (rst_i)
		both_crest_s |=> two_r.levels == $past(buf_r))
		else $error("crest copy missed with both points");

	// Complementary mode ignores the clear event.
	compl_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_r == MODE_COMPL) && clear_i && !crest_i && !trough_i && !wr_two
		|=> $stable(two_r.levels))
		else $error("clear copied in complementary mode");

	// Reset-synchronized mode copies on the clear event and on nothing else.
	rsync_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_r == MODE_RSYNC) && !clear_i && !wr_two |=> $stable(two_r.levels))
		else $error("copy without clear in reset-synchronized mode");

	// Outside the PWM modes the buffer is never copied.
	normal_nocopy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pwm_mode && !wr_two |=> $stable(two_r.levels))
		else $error("copy outside PWM modes");

	// Outside the PWM modes the pins follow the phase inputs unchanged.
	normal_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pwm_mode |=> out_r == $past(phase_on_i))
		else $error("pins inverted outside PWM modes");

	// Reverse pin ch4_out_d shows its level bit once active.
	rev_d4_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rev_on_s ##0 phase_on_i[5] |=> ch4_out_d_o == $past(two_r.levels[5]))
		else $error("ch4_out_d active level wrong");

	// Reverse pin ch4_out_c shows its level bit once active.
	rev_c4_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rev_on_s ##0 phase_on_i[3] |=> ch4_out_c_o == $past(two_r.levels[3]))
		else $error("ch4_out_c active level wrong");

	// Reverse pin ch3_out_d shows its level bit once active.
	rev_d3_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rev_on_s ##0 phase_on_i[1] |=> ch3_out_d_o == $past(two_r.levels[1]))
		else $error("ch3_out_d active level wrong");

	// Positive pin ch4_out_b shows its level bit while active, with no dead time.
	pos_b4_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pos_on_s ##0 phase_on_i[4] |=> ch4_out_b_o == $past(two_r.levels[4]))
		else $error("ch4_out_b active level wrong");

	// Positive pin ch4_out_a shows its level bit while active, with no dead time.
	pos_a4_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pos_on_s ##0 phase_on_i[2] |=> ch4_out_a_o == $past(two_r.levels[2]))
		else $error("ch4_out_a active level wrong");

	// Positive pin ch3_out_b shows its level bit while active, with no dead time.
	pos_b3_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pos_on_s ##0 phase_on_i[0] |=> ch3_out_b_o == $past(two_r.levels[0]))
		else $error("ch3_out_b active level wrong");

	// An inactive reverse pin rests at the inverse of its level bit.
	rev_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_mode && one_r[ONE_TSEL_BIT] && !phase_on_i[5]
		|=> ch4_out_d_o == !$past(two_r.levels[5]))
		else $error("ch4_out_d initial level wrong");

	// An inactive positive pin rests at the inverse of its level bit.
	pos_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_mode && one_r[ONE_TSEL_BIT] && !phase_on_i[0]
		|=> ch3_out_b_o == !$past(two_r.levels[0]))
		else $error("ch3_out_b initial level wrong");

	// The dead-time count starts from zero whenever counting starts.
	dead_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(counting_i) |-> !dead_done)
		else $error("dead time already over at count start");

	// A write to the second register lands at once when no copy competes.
	write_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_two && !do_copy |=> two_r == $past(wb_dat_i[7:0]))
		else $error("second register write lost");

	// The level buffer takes software writes.
	buf_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_buf |=> buf_r == $past(wb_dat_i[5:0]))
		else $error("level buffer write lost");

	// The first register takes software writes.
	one_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_one |=> one_r == $past(wb_dat_i[2:0]))
		else $error("first register write lost");

	// Every request taken is answered in the next cycle.
	ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req |=> wb_ack_o)
		else $error("request not answered");

	// A read of the second register returns it with the upper bits zero.
	read_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && !wb_we_i && (wb_adr_i == ADDR_TWO)
		|=> wb_dat_o == {24'h00_0000, $past(two_r)})
		else $error("second register read wrong");

endmodule
`default_nettype wire

// [core/pwm_level_pkg.sv]
`default_nettype none
package pwm_level_pkg;

	// Register byte offsets on the bus.
	localparam logic [3:0] ADDR_ONE  = 4'h0;
	localparam logic [3:0] ADDR_TWO  = 4'h4;
	localparam logic [3:0] ADDR_BUF  = 4'h8;
	localparam logic [3:0] ADDR_MODE = 4'hC;

	// Field positions in the first output control register.
	localparam int ONE_TSEL_BIT = 2;
	localparam int ONE_REV_BIT  = 1;
	localparam int ONE_POS_BIT  = 0;

	// Copy timing codes of the second output control register.
	localparam logic [1:0] COPY_NONE   = 2'h0;
	localparam logic [1:0] COPY_CREST  = 2'h1;
	localparam logic [1:0] COPY_TROUGH = 2'h2;
	localparam logic [1:0] COPY_BOTH   = 2'h3;

	// Reverse-phase outputs sit on the odd level bits.
	localparam logic [5:0] REV_MASK = 6'h2A;

	// Timer operating modes; code 11 is illegal and behaves as normal.
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_COMPL  = 2'b01,
		MODE_RSYNC  = 2'b10
	} pwm_mode_t;

	// Second output control register layout.
	typedef struct packed {
		logic [1:0] copy_timing;
		logic [5:0] levels;
	} level_two_t;

	localparam level_two_t TWO_RESET   = 8'h00;
	localparam logic [5:0] LEVEL_RESET = 6'h00;
	localparam logic [2:0] ONE_RESET   = 3'h0;
	localparam logic [1:0] MODE_RESET  = 2'h0;

	// Timing: clock period and default dead time.
	localparam int CLK_PERIOD_NS = 5;
	localparam int DEAD_TIME_NS  = 100;
	localparam int DEAD_CYCLES   = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage
`default_nettype wire

// [bench/gate_drive_model.sv]
`default_nettype none
// Power-stage gate inputs, gathered into one vector in phase order.
module gate_drive_model (
	input  wire logic       ch4_out_d_i,
	input  wire logic       ch4_out_b_i,
	input  wire logic       ch4_out_c_i,
	input  wire logic       ch4_out_a_i,
	input  wire logic       ch3_out_d_i,
	input  wire logic       ch3_out_b_i,
	output logic      [5:0] gate_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Odd indices are the reverse-phase switches.
	assign gate_o = {ch4_out_d_i, ch4_out_b_i, ch4_out_c_i,
		ch4_out_a_i, ch3_out_d_i, ch3_out_b_i};
endmodule
`default_nettype wire

// [bench/pwm_output_level_select_tb_top.sv]
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module pwm_output_level_select_tb_top import pwm_level_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, cyc, stb, we, ack, crest, trough, clr, cnt;
	logic [3:0]  adr, sel;
	logic [31:0] wdat, rdat, seed, r;
	logic [5:0]  on, gate;
	logic        p5, p4, p3, p2, p1, p0;
	int          bad_count, tests_run, cycles;

	pwm_output_level_select #(.DEAD_CNT(3)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .crest_i(crest),
		.trough_i(trough), .clear_i(clr), .counting_i(cnt), .phase_on_i(on),
		.ch4_out_d_o(p5), .ch4_out_b_o(p4), .ch4_out_c_o(p3), .ch4_out_a_o(p2),
		.ch3_out_d_o(p1), .ch3_out_b_o(p0));
	gate_drive_model i_gate (.ch4_out_d_i(p5), .ch4_out_b_i(p4), .ch4_out_c_i(p3),
		.ch4_out_a_i(p2), .ch3_out_d_i(p1), .ch3_out_b_i(p0), .gate_o(gate));

	// Free-running clock at 200 MHz.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Xorshift source with a fixed seed.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Whether a counter event copies the buffer for a mode and timing code.
	function automatic logic cp(int m, int c, int e);
		if (m == 1) return (e == 0 && c[0]) || (e == 1 && c[1]);
		if (m == 2) return e == 2 && c == 1;
		return 1'b0;
	endfunction

	// Expected pin vector from the register contents and the phase inputs.
	function automatic logic [5:0] exp_pins(int m, logic [2:0] o, logic [5:0] lv, logic dd);
		logic [5:0] l;
		logic [5:0] a;
		for (int i = 0; i < 6; i++) l[i] = o[2] ? lv[i] : o[i % 2];
		a = on & {6{cnt}} & (dd ? 6'h3F : ~REV_MASK);
		if (m == 0 || m == 3) return on;
		return ~(l ^ a);
	endfunction

	// One classic Wishbone cycle; waits for ack, the bench timeout ends a hang.
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	// Main sequence.
	initial begin
		logic [7:0] q;
		logic [1:0] t;
		{cyc, stb, we, crest, trough, clr, cnt} = 7'h00;
		{adr, wdat, on} = '0;
		sel   = 4'hF;
		seed  = 32'h26DBDB3C;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADDR_TWO, 8'h00, q);
		`CHK("two_reset", 8'h00, q)
		wb(1'b1, 4'h6, 8'hFF, q);
		wb(1'b0, 4'h6, 8'h00, q);
		`CHK("unmapped", 8'h00, q)
		sel <= 4'hE;
		wb(1'b1, ADDR_TWO, 8'hFF, q);
		sel <= 4'hF;
		wb(1'b0, ADDR_TWO, 8'h00, q);
		`CHK("lane_off", 8'h00, q)
		for (int m = 0; m < 3; m++) for (int c = 0; c < 4; c++) for (int e = 0; e < 3; e++) begin
			r = rnd();
			t = (m == 2) ? 2'(c % 2) : 2'(c);
			wb(1'b1, ADDR_BUF, {2'h0, r[5:0]}, q);
			wb(1'b1, ADDR_TWO, {t, r[13:8]}, q);
			wb(1'b1, ADDR_MODE, 8'(m), q);
			wb(1'b0, ADDR_TWO, 8'h00, q);
			`CHK("two_rw", {t, r[13:8]}, q)
			crest  <= (e == 0);
			trough <= (e == 1);
			clr    <= (e == 2);
			@(posedge clk_i);
			{crest, trough, clr} <= 3'h0;
			wb(1'b0, ADDR_TWO, 8'h00, q);
			`CHK("copy", {t, cp(m, t, e) ? r[5:0] : r[13:8]}, q)
		end
		for (int m = 0; m < 4; m++) repeat (3) begin
			r = rnd();
			cnt <= 1'b0;
			on  <= r[13:8];
			wb(1'b1, ADDR_MODE, 8'(m), q);
			wb(1'b1, ADDR_ONE, {5'h0, r[2:0]}, q);
			wb(1'b1, ADDR_TWO, {2'h0, r[21:16]}, q);
			repeat (2) @(posedge clk_i);
			`CHK("idle", exp_pins(m, r[2:0], r[21:16], 1'b0), gate)
			cnt <= 1'b1;
			repeat (2) @(posedge clk_i);
			`CHK("early", exp_pins(m, r[2:0], r[21:16], 1'b0), gate)
			repeat (8) @(posedge clk_i);
			`CHK("active", exp_pins(m, r[2:0], r[21:16], 1'b1), gate)
		end
		// A reset in mid-run clears a register that was written.
		wb(1'b1, ADDR_TWO, 8'hFF, q);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADDR_TWO, 8'h00, q);
		`CHK("two_rerun", 8'h00, q)
		wrap_up();
	end
endmodule
`default_nettype wire
